/* File: ddrmci_pkg.sv */
// Shared constants for the memory module command interface.
// Assumes a single-rank x64 module with four internal banks.
package ddrmci_pkg;

  // ----------------------------------------------------------------
  // Command codes {row strobe, column strobe, write enable}, all low active
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;

  // ----------------------------------------------------------------
  // Address and mode register fields
  // ----------------------------------------------------------------
  localparam int AP_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam logic [1:0] MR_SEL_BASE = 2'h0;
  localparam logic [1:0] MR_SEL_EXT = 2'h1;
  localparam logic [12:0] MODE_RST = 13'h0000;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [3:0] BEATS_2 = 4'h2;
  localparam logic [3:0] BEATS_4 = 4'h4;
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam logic [2:0] CL_MIN = 3'h2;

  // ----------------------------------------------------------------
  // Power state codes reported to the system side
  // ----------------------------------------------------------------
  localparam logic [1:0] PWRC_ON = 2'h0;
  localparam logic [1:0] PWRC_PPD = 2'h1;
  localparam logic [1:0] PWRC_APD = 2'h2;
  localparam logic [1:0] PWRC_SR = 2'h3;

  typedef enum logic [2:0] {PWR_ON = 3'b001, PWR_PPD = 3'b010, PWR_APD = 3'b100} ddrmci_pwr_t;
  typedef enum logic [3:0] {B_IDLE = 4'b0001, B_RWAIT = 4'b0010, B_READ = 4'b0100, B_WRITE = 4'b1000} ddrmci_burst_t;

endpackage

/* File: ddrmci_top.sv */
// Command decoder, bank tracking, power states and data path of the module.
// Assumes the differential clock pair is resolved to one clock ck outside,
// and that the far controller obeys the module's timing.
`timescale 1ns/10ps

// What this block does
// - Address and control are sampled on the rising edge of the link clock.
// - Read data and strobes are launched from link clock edges.
// - Clock enable low stops internal clock, input capture and output drive.
// - Low enable gives precharge power-down or self refresh if idle, else active power-down.
// - Power-down entry, exit and self-refresh entry happen at sampled clock edges.
// - Self-refresh exit and output disable follow clock enable without a clock.
// - In power-down or self refresh, command and data inputs are ignored.
// - Chip select low enables decoding; high masks every command.
// - Command comes from row, column and write strobes plus chip select.
// - Bank address picks the bank for activate, read, write and precharge.
// - Activate takes the row; read and write take column plus auto-precharge bit.
// - Precharge closes the addressed bank, or all banks with bit ten high.
// - Load mode register writes the address inputs as op-code.
// - Bank address chooses base or extended mode register.
// - Module drives strobes on reads; controller drives them on writes.
// - Read strobes are edge aligned with read data.
// - Write mask low stores the lane, high blocks it.
// - Write masks never affect read data.
// - Data moves over a 64-bit two-way bus.
module ddrmci_top #(
  parameter int ADDR_W = 13,
  parameter int MEM_ROW_W = 2,
  parameter int MEM_COL_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [63:0] dq_in,
  output logic [63:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dqs_in,
  output logic [7:0] dqs_out,
  output logic dqs_oe,
  input wire logic [7:0] dm,
  output logic [1:0] pwr_state,
  output logic [ADDR_W-1:0] mode_reg,
  output logic [ADDR_W-1:0] ext_mode_reg,
  output logic status_upd
);

  localparam int IDX_W = 2 + MEM_ROW_W + MEM_COL_W;
  localparam int WORD_W = 2 + 2 * ADDR_W;

  // ----------------------------------------------------------------
  // Link domain: command sampling and decode
  // ----------------------------------------------------------------
  logic cke_q;
  logic sr_flag;
  ddrmci_pkg::ddrmci_pwr_t pwr;
  ddrmci_pkg::ddrmci_burst_t bst;
  logic [3:0] bank_open;
  logic [ADDR_W-1:0] row_q [4];
  logic [ADDR_W-1:0] mode_q;
  logic [ADDR_W-1:0] emode_q;
  logic [2:0] cmd;
  logic cmd_ok;
  logic sr_entry;
  logic pd_entry;

  assign cmd = {ras_n, cas_n, we_n};
  // Inputs only count with the clock enabled on this edge and the last one
  assign cmd_ok = cke && cke_q && !sr_flag && (pwr == ddrmci_pkg::PWR_ON) && !cs_n;
  assign sr_entry = cke_q && !cke && !sr_flag && !cs_n && (cmd == ddrmci_pkg::CMD_REF) && (bank_open == 4'h0);
  assign pd_entry = cke_q && !cke && !sr_flag && (pwr == ddrmci_pkg::PWR_ON) && !sr_entry;

  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  // Self refresh may end with the clock stopped, so enable clears it directly
  always_ff @(posedge ck or posedge rst or posedge cke) begin
    if (rst) begin
      sr_flag <= 1'b0;
    end else if (cke) begin
      sr_flag <= 1'b0;
    end else if (sr_entry) begin
      sr_flag <= 1'b1;
    end
  end

  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      pwr <= ddrmci_pkg::PWR_ON;
    end else begin
      case (pwr)
        ddrmci_pkg::PWR_ON: begin
          if (pd_entry) begin
            pwr <= (bank_open == 4'h0) ? ddrmci_pkg::PWR_PPD : ddrmci_pkg::PWR_APD;
          end
        end
        ddrmci_pkg::PWR_PPD, ddrmci_pkg::PWR_APD: begin
          if (cke) begin
            pwr <= ddrmci_pkg::PWR_ON;
          end
        end
        default: pwr <= ddrmci_pkg::PWR_ON;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      mode_q <= ddrmci_pkg::MODE_RST;
      emode_q <= ddrmci_pkg::MODE_RST;
    end else if (cmd_ok && cmd == ddrmci_pkg::CMD_LMR) begin
      if (ba == ddrmci_pkg::MR_SEL_BASE) begin
        mode_q <= addr;
      end else if (ba == ddrmci_pkg::MR_SEL_EXT) begin
        emode_q <= addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Burst engine and data path
  // ----------------------------------------------------------------
  logic [63:0] mem [2**IDX_W];
  logic [1:0] cur_bank;
  logic [MEM_COL_W-1:0] cur_col;
  logic cur_ap;
  logic [3:0] beats;
  logic [2:0] lat;
  logic [3:0] bl_beats;
  logic [2:0] cl_eff;
  logic [IDX_W-1:0] idx;
  logic burst_done;
  logic rd_go;
  logic wr_go;

  always_comb begin
    case (mode_q[ddrmci_pkg::MR_BL_LSB +: 3])
      ddrmci_pkg::BL_CODE_4: bl_beats = ddrmci_pkg::BEATS_4;
      ddrmci_pkg::BL_CODE_8: bl_beats = ddrmci_pkg::BEATS_8;
      default: bl_beats = ddrmci_pkg::BEATS_2;
    endcase
    cl_eff = mode_q[ddrmci_pkg::MR_CL_LSB +: 3];
    if (cl_eff < ddrmci_pkg::CL_MIN) begin
      cl_eff = ddrmci_pkg::CL_MIN;
    end
  end

  // A new access is only taken between bursts; overlapping ones are dropped
  assign rd_go = cmd_ok && (cmd == ddrmci_pkg::CMD_RD) && (bst == ddrmci_pkg::B_IDLE);
  assign wr_go = cmd_ok && (cmd == ddrmci_pkg::CMD_WR) && (bst == ddrmci_pkg::B_IDLE);
  assign idx = {cur_bank, row_q[cur_bank][MEM_ROW_W-1:0], cur_col};
  assign burst_done = cke && (beats == 4'h1) && (bst == ddrmci_pkg::B_READ || bst == ddrmci_pkg::B_WRITE);

  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      bst <= ddrmci_pkg::B_IDLE;
      cur_bank <= 2'h0;
      cur_col <= '0;
      cur_ap <= 1'b0;
      beats <= 4'h0;
      lat <= 3'h0;
    end else if (cke) begin
      case (bst)
        ddrmci_pkg::B_IDLE: begin
          if (rd_go || wr_go) begin
            cur_bank <= ba;
            cur_col <= addr[MEM_COL_W-1:0];
            cur_ap <= addr[ddrmci_pkg::AP_BIT];
            beats <= bl_beats;
            lat <= cl_eff;
            bst <= rd_go ? ddrmci_pkg::B_RWAIT : ddrmci_pkg::B_WRITE;
          end
        end
        ddrmci_pkg::B_RWAIT: begin
          lat <= lat - 3'h1;
          if (lat == 3'h2) begin
            bst <= ddrmci_pkg::B_READ;
          end
        end
        ddrmci_pkg::B_READ, ddrmci_pkg::B_WRITE: begin
          beats <= beats - 4'h1;
          cur_col <= cur_col + 1'b1;
          if (beats == 4'h1) begin
            bst <= ddrmci_pkg::B_IDLE;
          end
        end
        default: bst <= ddrmci_pkg::B_IDLE;
      endcase
    end
  end

  // Stores one word per write beat, lane by lane
  always_ff @(posedge ck) begin
    if (cke && bst == ddrmci_pkg::B_WRITE) begin
      for (int i = 0; i < 8; i++) begin
        if (!dm[i]) begin
          mem[idx][8*i +: 8] <= dq_in[8*i +: 8];
        end
      end
    end
  end

  // Read data ignores the mask inputs altogether
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      dq_out <= 64'h0;
      dqs_out <= 8'h00;
    end else if (cke && bst == ddrmci_pkg::B_READ) begin
      dq_out <= mem[idx];
      dqs_out <= ~dqs_out;
    end else if (!(cke && bst == ddrmci_pkg::B_READ) && bst != ddrmci_pkg::B_READ) begin
      dqs_out <= 8'h00;
    end
  end

  // Drivers drop at once when enable falls, clock or no clock
  always_ff @(posedge ck or posedge rst or negedge cke) begin
    if (rst) begin
      dq_oe <= 1'b0;
      dqs_oe <= 1'b0;
    end else if (!cke) begin
      dq_oe <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      dq_oe <= (bst == ddrmci_pkg::B_READ);
      dqs_oe <= (bst == ddrmci_pkg::B_READ);
    end
  end

  // ----------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      bank_open <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        row_q[b] <= '0;
      end
    end else begin
      if (burst_done && cur_ap) begin
        bank_open[cur_bank] <= 1'b0;
      end
      if (cmd_ok && cmd == ddrmci_pkg::CMD_ACT) begin
        bank_open[ba] <= 1'b1;
        row_q[ba] <= addr;
      end else if (cmd_ok && cmd == ddrmci_pkg::CMD_PRE) begin
        if (addr[ddrmci_pkg::AP_BIT]) begin
          bank_open <= 4'h0;
        end else begin
          bank_open[ba] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status crossing to the system clock (toggle handshake)
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] word_now;
  logic [WORD_W-1:0] hold;
  logic req;
  logic ack_s1;
  logic ack_s2;
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic [1:0] pwr_code;

  always_comb begin
    if (sr_flag) begin
      pwr_code = ddrmci_pkg::PWRC_SR;
    end else if (pwr == ddrmci_pkg::PWR_PPD) begin
      pwr_code = ddrmci_pkg::PWRC_PPD;
    end else if (pwr == ddrmci_pkg::PWR_APD) begin
      pwr_code = ddrmci_pkg::PWRC_APD;
    end else begin
      pwr_code = ddrmci_pkg::PWRC_ON;
    end
  end
  assign word_now = {pwr_code, mode_q, emode_q};

  // Hold stays put until the other side acknowledges it
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      hold <= {ddrmci_pkg::PWRC_ON, ddrmci_pkg::MODE_RST, ddrmci_pkg::MODE_RST};
      req <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= req_s3;
      ack_s2 <= ack_s1;
      if (req == ack_s2 && word_now != hold) begin
        hold <= word_now;
        req <= ~req;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
      pwr_state <= ddrmci_pkg::PWRC_ON;
      mode_reg <= ddrmci_pkg::MODE_RST;
      ext_mode_reg <= ddrmci_pkg::MODE_RST;
      status_upd <= 1'b0;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      status_upd <= (req_s2 != req_s3);
      if (req_s2 != req_s3) begin
        {pwr_state, mode_reg, ext_mode_reg} <= hold;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence sr_cmd_s;
    cke_q && !cke && !cs_n && cmd == ddrmci_pkg::CMD_REF && bank_open == 4'h0 && !sr_flag;
  endsequence
  sequence stays_low_s;
    !cke ##1 !cke;
  endsequence

  cs_mask_a: assert property (@(posedge ck) disable iff (rst)
    (cs_n && bst == ddrmci_pkg::B_IDLE) |=> $stable(bank_open) && $stable(mode_q))
    else $error("command taken with chip select high");
  act_open_a: assert property (@(posedge ck) disable iff (rst)
    (cmd_ok && cmd == ddrmci_pkg::CMD_ACT) |=> bank_open[$past(ba)] && row_q[$past(ba)] == $past(addr))
    else $error("activate did not open the bank");
  pre_all_a: assert property (@(posedge ck) disable iff (rst)
    (cmd_ok && cmd == ddrmci_pkg::CMD_PRE && addr[ddrmci_pkg::AP_BIT]) |=> bank_open == 4'h0)
    else $error("precharge all left a bank open");
  pre_one_a: assert property (@(posedge ck) disable iff (rst)
    (cmd_ok && cmd == ddrmci_pkg::CMD_PRE && !addr[ddrmci_pkg::AP_BIT]) |=> !bank_open[$past(ba)])
    else $error("precharge left its bank open");
  mode_load_a: assert property (@(posedge ck) disable iff (rst)
    (cmd_ok && cmd == ddrmci_pkg::CMD_LMR && ba == ddrmci_pkg::MR_SEL_BASE) |=> mode_q == $past(addr) && $stable(emode_q))
    else $error("mode register load went astray");
  out_off_a: assert property (@(posedge ck) disable iff (rst)
    !cke |-> !dq_oe && !dqs_oe)
    else $error("outputs driven with clock enable low");
  sr_enter_a: assert property (@(posedge ck) disable iff (rst)
    sr_cmd_s ##1 stays_low_s |-> sr_flag && pwr == ddrmci_pkg::PWR_ON)
    else $error("self refresh not entered");
  pd_enter_a: assert property (@(posedge ck) disable iff (rst)
    (pd_entry && bank_open == 4'h0) |=> pwr == ddrmci_pkg::PWR_PPD)
    else $error("precharge power-down not entered");
  pd_block_a: assert property (@(posedge ck) disable iff (rst)
    (pwr != ddrmci_pkg::PWR_ON || sr_flag) |=> $stable(mode_q) && $stable(row_q[0]))
    else $error("command taken during power-down");
  rd_strobe_a: assert property (@(posedge ck) disable iff (rst)
    $rose(dq_oe) |-> dqs_oe && dqs_out == 8'hff)
    else $error("read strobe not aligned with data");

endmodule

/* File: ddrmci_host.sv */
// Behavioural host controller for the link side of the module.
// Assumes it shares the link clock ck with the module and is called from the bench.
`timescale 1ns/10ps
module ddrmci_host (
  input wire logic ck,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic [63:0] dq_in,
  output logic [7:0] dqs_in,
  output logic [7:0] dm
);
  logic [63:0] wdata;
  logic [7:0] wmask;
  logic wr_on;
  logic [63:0] idle_pat;

  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 13'h0000;
    dqs_in = 8'h00;
    wdata = 64'h0;
    wmask = 8'h00;
    wr_on = 1'b0;
    idle_pat = 64'h5a3c_96e1_0ff0_c33c;
  end

  // ----------------------------------------------------------------
  // Data lanes
  // ----------------------------------------------------------------
  // Released lines flip every cycle so a stale value is never mistaken for data
  always @(posedge ck) idle_pat <= ~idle_pat;
  assign dq_in = wr_on ? wdata : idle_pat;
  assign dm = wr_on ? wmask : idle_pat[7:0];
  // Falling edge puts strobe edges mid-beat
  always @(negedge ck) dqs_in <= wr_on ? ~dqs_in : idle_pat[15:8];

  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  task automatic cmd(input logic sel_n, input logic [2:0] code, input logic [1:0] bank, input logic [12:0] a);
    @(posedge ck);
    {cs_n, ras_n, cas_n, we_n} <= {sel_n, code};
    ba <= bank;
    addr <= a;
    @(posedge ck);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    ba <= ~bank;
    addr <= ~a;
  endtask

  task automatic wr_burst(input logic [1:0] bank, input logic [12:0] col, input int beats,
                          input logic [63:0] d [8], input logic [7:0] m);
    cmd(1'b0, ddrmci_pkg::CMD_WR, bank, col);
    wr_on <= 1'b1;
    wmask <= m;
    for (int i = 0; i < beats; i++) begin
      wdata <= d[i];
      @(posedge ck);
    end
    wr_on <= 1'b0;
  endtask

  task automatic set_cke(input logic lvl, input logic sref);
    @(posedge ck);
    cke <= lvl;
    if (sref) {cs_n, ras_n, cas_n, we_n} <= {1'b0, ddrmci_pkg::CMD_REF};
    @(posedge ck);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    @(posedge ck);
  endtask
endmodule

/* File: ddrmci_tb.sv */
// Self-checking bench for the module command interface.
// Assumes ddrmci_host on the link side and expectations built from the rules.
`timescale 1ns/10ps
module testbench;
  localparam int BEATS = 4;
  localparam int RD_CL = 3;
  localparam logic [12:0] MODE_OP = 13'h0032;
  localparam logic [12:0] EXT_OP = 13'h0155;
  logic clk, rst, ck, cke, cs_n, ras_n, cas_n, we_n;
  logic [1:0] ba;
  logic [12:0] addr;
  logic [63:0] dq_in, dq_out;
  logic [7:0] dqs_in, dqs_out, dm;
  logic dq_oe, dqs_oe, status_upd;
  logic [1:0] pwr_state;
  logic [12:0] mode_reg, ext_mode_reg;
  logic [63:0] mem [256];
  int n_mismatch, tests_run;
  int n_upd = 0;

  // Counts status pulses so the update strobe itself is judged
  always @(posedge clk) begin
    if (status_upd === 1'b1) n_upd++;
  end

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #7;
    forever #32 ck = ~ck;
  end
  initial begin
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  end

  ddrmci_host ddrmci_host_inst (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dq_in(dq_in), .dqs_in(dqs_in), .dm(dm));
  ddrmci_top #(.ADDR_W(13), .MEM_ROW_W(2), .MEM_COL_W(4)) ddrmci_top_inst (.clk(clk), .rst(rst), .ck(ck),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dm(dm),
    .pwr_state(pwr_state), .mode_reg(mode_reg), .ext_mode_reg(ext_mode_reg), .status_upd(status_upd));

  // ----------------------------------------------------------------
  // Comparison and helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_ctl(input string what, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Status copies lag by a few cycles and coalesce, so allow generous slack
  task automatic settle;
    repeat (30) @(posedge clk);
  endtask

  task automatic do_wr(input logic [1:0] bank, input logic [3:0] col, input logic [7:0] seed, input logic [7:0] m);
    logic [63:0] d [8];
    logic [7:0] idx;
    for (int i = 0; i < BEATS; i++) begin
      d[i] = 64'h0123456789abcdef ^ {8{seed + 8'(i)}};
      idx = {bank, 2'h1, col + 4'(i)};
      for (int j = 0; j < 8; j++) begin
        if (!m[j]) mem[idx][8*j +: 8] = d[i][8*j +: 8];
      end
    end
    ddrmci_host_inst.wr_burst(bank, {9'h0, col}, BEATS, d, m);
  endtask

  task automatic do_rd(input logic [1:0] bank, input logic [3:0] col, input logic ap);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_RD, bank, {2'h0, ap, 6'h0, col});
    repeat (RD_CL - 1) @(posedge ck);
    for (int i = 0; i < BEATS; i++) begin
      @(posedge ck);
      #1;
      chk_ctl("dq_oe", 13'h1, {12'h0, dq_oe});
      chk_word("dq_out", mem[{bank, 2'h1, col + 4'(i)}], dq_out);
      chk_ctl("dqs_out", i[0] ? 13'h0 : 13'h0ff, {5'h0, dqs_out});
    end
    @(posedge ck);
    #1;
    chk_ctl("dqs_oe", 13'h0, {12'h0, dqs_oe});
  endtask

  task automatic power_cycle(input logic sref, input logic [1:0] exp);
    ddrmci_host_inst.set_cke(1'b0, sref);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_LMR, ddrmci_pkg::MR_SEL_EXT, 13'h0000);
    settle;
    chk_ctl("pwr_state", {11'h0, exp}, {11'h0, pwr_state});
    chk_ctl("ext_mode_reg", EXT_OP, ext_mode_reg);
    chk_ctl("dq_oe", 13'h0, {12'h0, dq_oe});
    ddrmci_host_inst.set_cke(1'b1, 1'b0);
    settle;
    chk_ctl("pwr_state", {11'h0, ddrmci_pkg::PWRC_ON}, {11'h0, pwr_state});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk_ctl("dq_oe", 13'h0, {12'h0, dq_oe});
    chk_ctl("pwr_state", {11'h0, ddrmci_pkg::PWRC_ON}, {11'h0, pwr_state});
    chk_ctl("mode_reg", ddrmci_pkg::MODE_RST, mode_reg);
    chk_word("dq_out", 64'h0, dq_out);
    chk_ctl("status_upd", 13'h0, {12'h0, status_upd});
  endtask

  task automatic t_mode;
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_LMR, ddrmci_pkg::MR_SEL_BASE, MODE_OP);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_LMR, ddrmci_pkg::MR_SEL_EXT, EXT_OP);
    // Deselected load must leave both registers alone
    ddrmci_host_inst.cmd(1'b1, ddrmci_pkg::CMD_LMR, ddrmci_pkg::MR_SEL_BASE, 13'h1fff);
    settle;
    chk_ctl("mode_reg", MODE_OP, mode_reg);
    chk_ctl("ext_mode_reg", EXT_OP, ext_mode_reg);
    chk_ctl("status_upd", 13'h1, {12'h0, n_upd > 0});
  endtask

  task automatic t_data;
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_ACT, 2'h2, 13'h0001);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_ACT, 2'h1, 13'h0001);
    do_wr(2'h2, 4'h4, 8'h10, 8'h00);
    do_wr(2'h1, 4'he, 8'h20, 8'h00);
    do_wr(2'h2, 4'h4, 8'h30, 8'h81);
    do_rd(2'h1, 4'he, 1'b0);
    do_rd(2'h2, 4'h4, 1'b1);
  endtask

  task automatic t_power;
    power_cycle(1'b0, ddrmci_pkg::PWRC_APD);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_PRE, 2'h1, 13'h0000);
    power_cycle(1'b0, ddrmci_pkg::PWRC_PPD);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_ACT, 2'h0, 13'h0001);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_ACT, 2'h3, 13'h0001);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_PRE, 2'h0, 13'h0000);
    power_cycle(1'b0, ddrmci_pkg::PWRC_APD);
    ddrmci_host_inst.cmd(1'b0, ddrmci_pkg::CMD_PRE, 2'h2, 13'h0400);
    power_cycle(1'b1, ddrmci_pkg::PWRC_SR);
  endtask

  task automatic complete_run;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    @(negedge rst);
    repeat (2) @(posedge ck);
    t_reset;
    t_mode;
    t_data;
    t_power;
    complete_run;
  end

  initial begin
    #200000;
    n_mismatch++;
    complete_run;
  end
endmodule
